//--- logic/ivm_pkg.sv
// Purpose: Constants and carriers for the interrupt vector mapper
// Assumes: 16-bit register port, 64 request numbers
// Notes: Sources not in the implemented map have no storage and read zero

package ivm_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_REQ = 64;
   localparam int NUM_FLAG_REGS = 4;
   localparam int NUM_PRIO_REGS = 16;
   localparam int VEC_OFFSET = 8;
   localparam logic [23:0] VT_BASE = 24'h000014;
   localparam logic [23:0] VT_STEP = 24'h000002;
   localparam logic [23:0] RESET_PC = 24'h000000;

   // Requests that have flag, enable and priority storage
   localparam logic [63:0] IMPL_MASK = 64'h0200_003F_FF1F_FFFF;

   // ----------------------------------------------------------------
   // Request numbers of named sources
   // ----------------------------------------------------------------
   localparam int REQ_EXT_A = 0;
   localparam int REQ_TIMER_ONE = 3;
   localparam int REQ_DMA_CHAN_ZERO_IRQ = 4;
   localparam int REQ_TIMER_TWO = 7;
   localparam int REQ_TIMER_THREE = 8;
   localparam int REQ_SPI_ERR = 9;
   localparam int REQ_SPI_DONE = 10;
   localparam int REQ_UART_RX = 11;
   localparam int REQ_UART_TX = 12;
   localparam int REQ_ADC = 13;
   localparam int REQ_DMA1 = 14;
   localparam int REQ_NVM = 15;
   localparam int REQ_CMP = 18;
   localparam int REQ_CHANGE = 19;
   localparam int REQ_EXT_B = 20;
   localparam int REQ_DMA2 = 24;
   localparam int REQ_TIMER_FOUR = 27;
   localparam int REQ_TIMER_FIVE = 28;
   localparam int REQ_EXT_C = 29;
   localparam int REQ_CAN_RX = 34;
   localparam int REQ_CAN_EVT = 35;
   localparam int REQ_DMA3 = 36;
   localparam int REQ_PWM_SEM = 57;

   // ----------------------------------------------------------------
   // Register map (word addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_FLAG_BASE = 8'h00;
   localparam logic [7:0] ADDR_ENABLE_BASE = 8'h10;
   localparam logic [7:0] ADDR_PRIO_BASE = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h40;
   localparam int PRIO_FIELD_STRIDE = 4;
   localparam logic [15:0] PRIO_FIELD_MASK = 16'h7777;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } ivm_bus_s;

   typedef struct packed {
      logic valid;
      logic [7:0] vector;
      logic [3:0] level;
      logic [5:0] req;
   } ivm_pick_s;

endpackage : ivm_pkg

//--- logic/ivm_arbiter.sv
// Purpose: Pick the enabled flagged request of highest priority
// Assumes: Priority fields are 3 bits, level 0 never interrupts
// Notes: Purely combinational; the top registers the result

`timescale 1ns/1ns

module ivm_arbiter (
   // Request state
   input wire logic [63:0] active,
   input wire logic [191:0] prio,
   // Result
   output ivm_pkg::ivm_pick_s pick
);

   always_comb begin
      pick = '0;
      // Ascending scan with strict greater keeps the lowest number on a tie
      for (int n = 0; n < ivm_pkg::NUM_REQ; n++) begin
         if (active[n] && (prio[n*3 +: 3] != 3'h0) &&
             (!pick.valid || ({1'b0, prio[n*3 +: 3]} > pick.level))) begin
            pick.valid = 1'b1;
            pick.level = {1'b0, prio[n*3 +: 3]};
            pick.req = 6'(n);
            pick.vector = 8'(n + ivm_pkg::VEC_OFFSET);
         end
      end
   end

endmodule : ivm_arbiter

//--- logic/ivm_top.sv
// Purpose: Interrupt source mapping, flag/enable/priority registers and vectoring
// Assumes: Peripheral event inputs are same-clock single-cycle or level pulses
// Notes: Reset is not vectored through this block
//
// How it works
// - Vector number is request number plus eight.
// - Vector table address is 0x14 plus two per vector above eight.
// - Equal priority ties go to the lowest request number.
// - Flag and enable sit in register n/16, bit n%16.
// - Three-bit priority fields, four per register, register n/4.
// - SPI error 9, SPI done 10, UART receive 11, transmit 12.
// - DMA channels zero to three on requests 4, 14, 24, 36.
// - External pins on requests 0, 20 and 29.
// - CAN receive 34 and event 35, only when CAN is present.
// - PWM special event match on request 57.
// - Write complete 15, ADC 13, comparator 18, input change 19.
// - Timers map to requests 3, 7, 8, 27, 28.
// - Reset raises no flag and is not vectored.
// - Reset clears registers and forces program counter to zero.
// - Hardware sets flags; only software writes and reset clear them.
// - A source reaches the core only when enabled.
// - Each source takes one of eight priority levels.
// - Pending vector number and level latch into a status register.
//
// The plain strobed port and the address map were chosen for this implementation.

`timescale 1ns/1ns

module ivm_top #(
   parameter bit CAN_PRESENT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // External pins, asynchronous
   input wire logic ext_pin_irq_a,
   input wire logic ext_pin_irq_b,
   input wire logic ext_pin_irq_c,
   // Peripheral events, same clock
   input wire logic capture_one_irq,
   input wire logic compare_one_irq,
   input wire logic compare_two_irq,
   input wire logic timer_one_irq,
   input wire logic [3:0] dma_chan_irq,
   input wire logic [3:0] timer_irq_two_to_five,
   input wire logic serial_periph_err_irq,
   input wire logic serial_periph_done_irq,
   input wire logic uart_one_rx_irq,
   input wire logic uart_one_tx_irq,
   input wire logic adc_done_irq,
   input wire logic nonvolatile_write_irq,
   input wire logic two_wire_target_irq,
   input wire logic comparator_event_irq,
   input wire logic input_change_irq,
   input wire logic can_rx_ready_irq,
   input wire logic can_event_irq,
   input wire logic pwm_special_match_irq,
   input wire logic [63:0] other_irq,
   // Core side
   output logic irq_req,
   output logic [7:0] pending_vector_number,
   output logic [3:0] new_priority_level,
   output logic [23:0] vector_addr,
   output logic [23:0] program_counter,
   output logic pc_load
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] pin_meta;
      logic [2:0] pin_sync;
      logic [2:0] pin_prev;
      logic [63:0] flag;
      logic [63:0] enable;
      logic [191:0] prio;
      logic [15:0] rdata;
      logic irq;
      logic [7:0] vec;
      logic [3:0] lvl;
      logic [23:0] vaddr;
      logic [23:0] pc;
      logic pc_load;
   } ivm_state_s;

   ivm_state_s state_reg;
   ivm_state_s state_next;
   ivm_pkg::ivm_bus_s bus;
   ivm_pkg::ivm_pick_s pick;
   logic [63:0] raise;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Vector table address for a vector number
   function automatic logic [23:0] vt_addr(input logic [7:0] vec);
      vt_addr = ivm_pkg::VT_BASE +
                24'((vec - 8'(ivm_pkg::VEC_OFFSET)) * ivm_pkg::VT_STEP);
   endfunction : vt_addr

   // Storage mask for a request, unlisted ones and CAN when absent drop out
   function automatic logic [63:0] impl_mask(input bit can);
      impl_mask = ivm_pkg::IMPL_MASK;
      if (!can) begin
         impl_mask[ivm_pkg::REQ_CAN_RX] = 1'b0;
         impl_mask[ivm_pkg::REQ_CAN_EVT] = 1'b0;
      end
   endfunction : impl_mask

   // ----------------------------------------------------------------
   // Source to request mapping
   // ----------------------------------------------------------------
   always_comb begin
      raise = other_irq;
      // Pins fire on rising edge after the synchroniser
      raise[ivm_pkg::REQ_EXT_A] = state_reg.pin_sync[0] & ~state_reg.pin_prev[0];
      raise[ivm_pkg::REQ_EXT_B] = state_reg.pin_sync[1] & ~state_reg.pin_prev[1];
      raise[ivm_pkg::REQ_EXT_C] = state_reg.pin_sync[2] & ~state_reg.pin_prev[2];
      raise[1] = capture_one_irq;
      raise[2] = compare_one_irq;
      raise[6] = compare_two_irq;
      raise[ivm_pkg::REQ_TIMER_ONE] = timer_one_irq;
      raise[ivm_pkg::REQ_TIMER_TWO] = timer_irq_two_to_five[0];
      raise[ivm_pkg::REQ_TIMER_THREE] = timer_irq_two_to_five[1];
      raise[ivm_pkg::REQ_TIMER_FOUR] = timer_irq_two_to_five[2];
      raise[ivm_pkg::REQ_TIMER_FIVE] = timer_irq_two_to_five[3];
      raise[ivm_pkg::REQ_DMA_CHAN_ZERO_IRQ] = dma_chan_irq[0];
      raise[ivm_pkg::REQ_DMA1] = dma_chan_irq[1];
      raise[ivm_pkg::REQ_DMA2] = dma_chan_irq[2];
      raise[ivm_pkg::REQ_DMA3] = dma_chan_irq[3];
      raise[ivm_pkg::REQ_SPI_ERR] = serial_periph_err_irq;
      raise[ivm_pkg::REQ_SPI_DONE] = serial_periph_done_irq;
      raise[ivm_pkg::REQ_UART_RX] = uart_one_rx_irq;
      raise[ivm_pkg::REQ_UART_TX] = uart_one_tx_irq;
      raise[ivm_pkg::REQ_ADC] = adc_done_irq;
      raise[ivm_pkg::REQ_NVM] = nonvolatile_write_irq;
      raise[16] = two_wire_target_irq;
      raise[ivm_pkg::REQ_CMP] = comparator_event_irq;
      raise[ivm_pkg::REQ_CHANGE] = input_change_irq;
      raise[ivm_pkg::REQ_CAN_RX] = can_rx_ready_irq;
      raise[ivm_pkg::REQ_CAN_EVT] = can_event_irq;
      raise[ivm_pkg::REQ_PWM_SEM] = pwm_special_match_irq;
      raise = raise & impl_mask(CAN_PRESENT);
   end

   // ----------------------------------------------------------------
   // Arbitration
   // ----------------------------------------------------------------
   ivm_arbiter u_arb (
      .active(state_reg.flag & state_reg.enable),
      .prio(state_reg.prio),
      .pick(pick)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [1:0] fidx;
      logic [3:0] pidx;
      logic [63:0] mask;
      logic [15:0] wprio;
      fidx = bus.addr[1:0];
      pidx = bus.addr[3:0];
      mask = impl_mask(CAN_PRESENT);
      wprio = '0;
      state_next = state_reg;
      state_next.pin_meta = {ext_pin_irq_c, ext_pin_irq_b, ext_pin_irq_a};
      state_next.pin_sync = state_reg.pin_meta;
      state_next.pin_prev = state_reg.pin_sync;
      state_next.pc_load = 1'b0;

      // Software writes first, so a hardware set in the same cycle wins
      if (bus.wr) begin
         if (bus.addr[7:2] == ivm_pkg::ADDR_FLAG_BASE[7:2]) begin
            state_next.flag[fidx*16 +: 16] = bus.wdata & mask[fidx*16 +: 16];
         end
         if (bus.addr[7:2] == ivm_pkg::ADDR_ENABLE_BASE[7:2]) begin
            state_next.enable[fidx*16 +: 16] = bus.wdata & mask[fidx*16 +: 16];
         end
         if (bus.addr[7:4] == ivm_pkg::ADDR_PRIO_BASE[7:4]) begin
            for (int k = 0; k < 4; k++) begin
               if (mask[pidx*4 + k]) begin
                  state_next.prio[(pidx*4 + k)*3 +: 3] =
                     bus.wdata[k*ivm_pkg::PRIO_FIELD_STRIDE +: 3];
               end
            end
         end
      end
      state_next.flag = state_next.flag | raise;

      state_next.rdata = '0;
      if (bus.rd) begin
         if (bus.addr[7:2] == ivm_pkg::ADDR_FLAG_BASE[7:2]) begin
            state_next.rdata = state_reg.flag[fidx*16 +: 16];
         end else if (bus.addr[7:2] == ivm_pkg::ADDR_ENABLE_BASE[7:2]) begin
            state_next.rdata = state_reg.enable[fidx*16 +: 16];
         end else if (bus.addr[7:4] == ivm_pkg::ADDR_PRIO_BASE[7:4]) begin
            for (int k = 0; k < 4; k++) begin
               wprio[k*ivm_pkg::PRIO_FIELD_STRIDE +: 3] = state_reg.prio[(pidx*4 + k)*3 +: 3];
            end
            state_next.rdata = wprio & ivm_pkg::PRIO_FIELD_MASK;
         end else if (bus.addr == ivm_pkg::ADDR_STATUS) begin
            state_next.rdata = {4'h0, state_reg.lvl, state_reg.vec};
         end
      end

      state_next.irq = pick.valid;
      if (pick.valid) begin
         state_next.vec = pick.vector;
         state_next.lvl = pick.level;
         state_next.vaddr = vt_addr(pick.vector);
      end else begin
         state_next.vec = '0;
         state_next.lvl = '0;
         state_next.vaddr = '0;
      end

      if (!rst_n) begin
         // Reset clears everything and restarts fetch at zero, no vector taken
         state_next = '0;
         state_next.pc = ivm_pkg::RESET_PC;
         state_next.pc_load = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = state_reg.rdata;
   assign irq_req = state_reg.irq;
   assign pending_vector_number = state_reg.vec;
   assign new_priority_level = state_reg.lvl;
   assign vector_addr = state_reg.vaddr;
   assign program_counter = state_reg.pc;
   assign pc_load = state_reg.pc_load;

endmodule : ivm_top

//--- sim/ivm_src_model.sv
// Purpose: Event sources standing beside the vector mapper
// Assumes: One fire strobe names one request number
// Notes: Pins stay high three cycles so the synchroniser sees an edge
`timescale 1ns/1ns
module ivm_src_model (
   // Control
   input wire logic clk,
   input wire logic fire,
   input wire logic [5:0] fire_req,
   // Events by request number
   output logic [63:0] ev
);
   localparam logic [63:0] PIN_MASK = 64'h0000_0000_2010_0001;
   logic [1:0] hold_reg;
   initial begin
      ev = 64'h0;
      hold_reg = 2'h0;
   end
   always @(posedge clk) begin
      if (fire) begin
         ev <= 64'h1 << fire_req;
         hold_reg <= 2'h2;
      end else if (hold_reg != 2'h0) begin
         ev <= ev & PIN_MASK;
         hold_reg <= hold_reg - 2'h1;
      end else begin
         ev <= 64'h0;
      end
   end
endmodule : ivm_src_model

//--- sim/ivm_top_props.sv
// Purpose: Port checks for the vector mapper
// Assumes: Status word is {4'h0, level, vector}
// Notes: Reset checks run with the disable switched off
`timescale 1ns/1ns
module ivm_top_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Core side
   input wire logic irq_req,
   input wire logic [7:0] pending_vector_number,
   input wire logic [3:0] new_priority_level,
   input wire logic [23:0] vector_addr,
   input wire logic [23:0] program_counter,
   input wire logic pc_load
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_vector_offset: assert property (irq_req |-> pending_vector_number inside {[8'h08:8'h47]})
      else $error("vector below offset");
   a_table_addr: assert property (irq_req |->
      vector_addr == 24'h14 + 24'h2 * ({16'h0, pending_vector_number} - 24'h8))
      else $error("table address wrong");
   a_idle_outputs: assert property (!irq_req |->
      vector_addr == 24'h0 && pending_vector_number == 8'h0 && new_priority_level == 4'h0)
      else $error("idle outputs not zero");
   a_level_range: assert property (irq_req |-> new_priority_level inside {[4'h1:4'h7]})
      else $error("level out of range");
   a_pend_hold: assert property ((!reg_wr) [*3] ##0 irq_req |=> irq_req)
      else $error("request dropped without write");
   a_status_read: assert property (reg_rd && reg_addr == 8'h40 |=>
      reg_rdata == {4'h0, $past(new_priority_level), $past(pending_vector_number)})
      else $error("status read wrong");
   a_unmapped_zero: assert property (reg_rd && reg_addr >= 8'h50 |=> reg_rdata == 16'h0)
      else $error("unmapped read not zero");
   a_reset_pc: assert property (disable iff (1'b0) !rst_n |=> pc_load && program_counter == 24'h0)
      else $error("reset redirect missing");
   a_pc_release: assert property (disable iff (1'b0) rst_n [*3] |-> !pc_load && program_counter == 24'h0)
      else $error("redirect held too long");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !irq_req && reg_rdata == 16'h0)
      else $error("reset raised a request");
endmodule : ivm_top_chk
bind ivm_top ivm_top_chk u_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .irq_req,
   .pending_vector_number, .new_priority_level, .vector_addr, .program_counter, .pc_load);

//--- sim/tb.sv
// Purpose: Self-checking bench for the vector mapper
// Assumes: CAN present; requests 0-20, 24-37 and 57 exist
// Notes: Every request number is fired once in t_map through the source model
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
   $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb;
   localparam logic [63:0] IMPL = 64'h0200_003F_FF1F_FFFF;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, fire = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
   logic [5:0] fire_req = 6'h00;
   logic [63:0] ev;
   logic irq_req, pc_load, nc_irq;
   logic [7:0] pending_vector_number;
   logic [3:0] new_priority_level;
   logic [23:0] vector_addr, program_counter;
   int fails = 0, checks_done = 0, cycles = 0;
   ivm_src_model u_src (.clk, .fire, .fire_req, .ev);
   ivm_top dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ext_pin_irq_a(ev[0]), .ext_pin_irq_b(ev[20]), .ext_pin_irq_c(ev[29]),
      .capture_one_irq(ev[1]), .compare_one_irq(ev[2]), .compare_two_irq(ev[6]),
      .timer_one_irq(ev[3]), .timer_irq_two_to_five({ev[28], ev[27], ev[8], ev[7]}),
      .dma_chan_irq({ev[36], ev[24], ev[14], ev[4]}),
      .serial_periph_err_irq(ev[9]), .serial_periph_done_irq(ev[10]),
      .uart_one_rx_irq(ev[11]), .uart_one_tx_irq(ev[12]),
      .adc_done_irq(ev[13]), .nonvolatile_write_irq(ev[15]), .two_wire_target_irq(ev[16]),
      .comparator_event_irq(ev[18]), .input_change_irq(ev[19]),
      .can_rx_ready_irq(ev[34]), .can_event_irq(ev[35]),
      .pwm_special_match_irq(ev[57]),
      .other_irq(ev & ~64'h0200_001C_391D_FFDF),
      .irq_req, .pending_vector_number, .new_priority_level, .vector_addr, .program_counter, .pc_load);
   // Same stimulus with the CAN module left out: its two requests must never raise
   ivm_top #(.CAN_PRESENT(1'b0)) dut_nocan (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(),
      .ext_pin_irq_a(ev[0]), .ext_pin_irq_b(ev[20]), .ext_pin_irq_c(ev[29]),
      .capture_one_irq(ev[1]), .compare_one_irq(ev[2]), .compare_two_irq(ev[6]),
      .timer_one_irq(ev[3]), .timer_irq_two_to_five({ev[28], ev[27], ev[8], ev[7]}),
      .dma_chan_irq({ev[36], ev[24], ev[14], ev[4]}),
      .serial_periph_err_irq(ev[9]), .serial_periph_done_irq(ev[10]),
      .uart_one_rx_irq(ev[11]), .uart_one_tx_irq(ev[12]),
      .adc_done_irq(ev[13]), .nonvolatile_write_irq(ev[15]), .two_wire_target_irq(ev[16]),
      .comparator_event_irq(ev[18]), .input_change_irq(ev[19]),
      .can_rx_ready_irq(ev[34]), .can_event_irq(ev[35]),
      .pwm_special_match_irq(ev[57]),
      .other_irq(ev & ~64'h0200_001C_391D_FFDF),
      .irq_req(nc_irq), .pending_vector_number(), .new_priority_level(), .vector_addr(), .program_counter(),
      .pc_load());
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         fails++;
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // Bus and event helpers
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk);
   endtask : rd
   task automatic fire_one(input int n);
      fire_req <= 6'(n);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
   endtask : fire_one
   // Waits a bounded time, since pins pass a synchroniser first
   task automatic expect_irq(input logic v, input logic [7:0] vec, input logic [3:0] lvl);
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         #1;
         if (irq_req === 1'b1 && pending_vector_number === vec && new_priority_level === lvl) break;
      end
      `CHK(irq_req, v)
      `CHK(pending_vector_number, v ? vec : 8'h00)
      `CHK(new_priority_level, v ? lvl : 4'h0)
      `CHK(vector_addr, v ? ivm_pkg::VT_BASE + ivm_pkg::VT_STEP * 24'(vec - 8'h08) : 24'h0)
      @(posedge clk);
   endtask : expect_irq
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_map();
      for (int n = 0; n < 64; n++) begin
         wr(ivm_pkg::ADDR_ENABLE_BASE + 8'(n / 16), 16'h0001 << (n % 16));
         wr(ivm_pkg::ADDR_PRIO_BASE + 8'(n / 4), 16'h0003 << (4 * (n % 4)));
         fire_one(n);
         expect_irq(IMPL[n], 8'(n + 8), 4'h3);
         #1;
         `CHK(nc_irq, IMPL[n] && !(n inside {ivm_pkg::REQ_CAN_RX, ivm_pkg::REQ_CAN_EVT}))
         rd(ivm_pkg::ADDR_FLAG_BASE + 8'(n / 16));
         `CHK(d, IMPL[n] ? 16'h0001 << (n % 16) : 16'h0000)
         wr(ivm_pkg::ADDR_FLAG_BASE + 8'(n / 16), 16'h0000);
         wr(ivm_pkg::ADDR_ENABLE_BASE + 8'(n / 16), 16'h0000);
         wr(ivm_pkg::ADDR_PRIO_BASE + 8'(n / 4), 16'h0000);
      end
   endtask : t_map
   task automatic t_prio();
      wr(8'h21, 16'h0005);
      wr(8'h23, 16'h0500);
      fire_one(4);
      fire_one(14);
      expect_irq(1'b0, 8'h00, 4'h0);
      rd(ivm_pkg::ADDR_FLAG_BASE);
      `CHK(d, 16'h4010)
      wr(ivm_pkg::ADDR_ENABLE_BASE, 16'h4010);
      expect_irq(1'b1, 8'd12, 4'h5);
      wr(8'h23, 16'h0600);
      expect_irq(1'b1, 8'd22, 4'h6);
      wr(8'h23, 16'h0700);
      expect_irq(1'b1, 8'd22, 4'h7);
      rd(ivm_pkg::ADDR_STATUS);
      `CHK(d, 16'h0716)
      wr(ivm_pkg::ADDR_FLAG_BASE, 16'h0000);
      expect_irq(1'b0, 8'h00, 4'h0);
   endtask : t_prio
   task automatic t_regs();
      wr(ivm_pkg::ADDR_PRIO_BASE, 16'hFFFF);
      rd(ivm_pkg::ADDR_PRIO_BASE);
      `CHK(d, 16'h7777)
      wr(8'h11, 16'hFFFF);
      rd(8'h11);
      `CHK(d, IMPL[31:16])
      wr(8'h50, 16'hFFFF);
      rd(8'h50);
      `CHK(d, 16'h0000)
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(pc_load, 1'b1)
      `CHK(program_counter, 24'h000000)
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(8'h11);
      `CHK(d, 16'h0000)
      rd(8'h01);
      `CHK(d, 16'h0000)
   endtask : t_regs
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_map();
      t_prio();
      t_regs();
      conclude();
   end
endmodule : tb
